//--- src/prs_pkg.sv
/*
  Package for the panel rail start-up and fault sequencer: state codes,
  register map, field positions and timing constants.
  Assumes a 25 MHz system clock and a 32-bit classic Wishbone register bus.
*/
package prs_pkg;

  // clock
  localparam int CLK_PERIOD_NS      = 40;

  // soft-start window and fault time-out with the typical delay capacitor
  localparam int SOFT_START_NS      = 2_000_000;
  localparam int FAULT_TIMEOUT_NS   = 50_000_000;
  localparam int SOFT_START_CYC     = (SOFT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FAULT_TIMEOUT_CYC  = (FAULT_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FAST_RAMP_CYC      = 64;
  localparam int CNT_W              = 21;

  // sequence
  localparam logic [2:0] PEAKS_FULL = 3'h6;

  // gray codes along the normal power-up path
  typedef enum logic [3:0] {
    ST_OFF     = 4'h0,
    ST_RAMP1   = 4'h1,
    ST_RAMP2   = 4'h3,
    ST_RAMP3   = 4'h2,
    ST_RAMP4   = 4'h6,
    ST_RAMP5   = 4'h7,
    ST_RAMP6   = 4'h5,
    ST_RUN     = 4'h4,
    ST_TIMEOUT = 4'hC,
    ST_LATCHED = 4'hD
  } prs_state_type;

  // rail enable vector bit positions
  localparam int RAIL_REF  = 0;
  localparam int RAIL_SW   = 1;
  localparam int RAIL_BST  = 2;
  localparam int RAIL_LOG  = 3;
  localparam int RAIL_NEG  = 4;
  localparam int RAIL_DBE  = 5;
  localparam int RAIL_POS  = 6;
  localparam int RAIL_W    = 7;

  // register map (byte addresses)
  localparam logic [3:0] ADR_CTRL   = 4'h0;
  localparam logic [3:0] ADR_STATUS = 4'h4;
  localparam logic [3:0] ADR_CAUSE  = 4'h8;

  // control fields
  localparam int CTRL_VARIANT = 0;
  localparam logic CTRL_RESET = 1'h0;

  // status fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_PEAK_LSB  = 4;
  localparam int ST_LATCH_BIT = 7;
  localparam int ST_SS_BIT    = 8;

  // fault cause bits
  localparam int CAUSE_PRE     = 0;
  localparam int CAUSE_REF     = 1;
  localparam int CAUSE_TEMP    = 2;
  localparam int CAUSE_RAIL    = 3;
  localparam int CAUSE_FINAL   = 4;
  localparam int CAUSE_TIMEOUT = 5;
  localparam int CAUSE_W       = 6;

endpackage : prs_pkg

//--- src/prs_sequencer.sv
/*
  Panel rail start-up and fault sequencer: steps through six delay-ramp
  peaks enabling the rails in order, latches off on any fault.
  Assumes analog comparators for supply, ramp peak and fault trip, all
  synchronous to CLK_I; registers are reached over classic Wishbone.
*/
// The register addresses and register access over Wishbone were left to the implementer.
module prs_sequencer #(
  parameter int SOFT_START_CYCLES    = prs_pkg::SOFT_START_CYC,
  parameter int FAULT_TIMEOUT_CYCLES = prs_pkg::FAULT_TIMEOUT_CYC,
  parameter int FAST_RAMP_CYCLES     = prs_pkg::FAST_RAMP_CYC
) (
  input  wire logic        CLK_I,                        // 25 MHz clock
  input  wire logic        RST_N_I,                      // async reset, low
  input  wire logic        CE_I,                         // clock enable
  input  wire logic        SUPPLY_OK_I,                  // input above start threshold
  input  wire logic        ENABLE_I,                     // enable pin
  input  wire logic        RAMP_PEAK_I,                  // ramp at upper threshold
  input  wire logic        FAULT_TRIP_I,                 // ramp at fault threshold
  input  wire logic        PRE_FAULT_I,                  // start-up fault check
  input  wire logic        REF_OK_I,                     // reference valid
  input  wire logic        OVERTEMP_I,                   // die above trip point
  input  wire logic        BOOST_FAULT_I,                // boost rail low
  input  wire logic        LOGIC_FAULT_I,                // logic rail low
  input  wire logic        NEG_FAULT_I,                  // negative gate rail fault
  input  wire logic        POS_FAULT_I,                  // positive gate rail fault
  input  wire logic        DBOOST_FAULT_I,               // delayed boost rail fault
  input  wire logic        SWITCH_FAULT_I,               // input switch node fault
  input  wire logic        DBEN_FAULT_I,                 // delayed boost enable pin fault
  output logic             REF_EN_O,                     // reference on
  output logic             INPUT_SWITCH_ENABLE_N_O,      // input switch on, low
  output logic             BOOST_RAIL_EN_O,              // boost rail on
  output logic             LOGIC_RAIL_EN_O,              // logic rail on
  output logic             SOFT_START_O,                 // soft-start active
  output logic             NEGATIVE_GATE_RAIL_EN_O,      // negative gate rail on
  output logic             DELAYED_BOOST_ENABLE_N_O,     // open-drain level
  output logic             DELAYED_BOOST_ENABLE_N_OE_O,  // open-drain drive
  output logic             POSITIVE_GATE_RAIL_EN_O,      // positive gate rail on
  output logic             RAMP_CHARGE_O,                // charge ramp cap
  output logic             RAMP_FAST_O,                  // fast charge current
  output logic             RAMP_DISCHARGE_O,             // discharge pulse
  output logic             RAMP_HOLD_O,                  // hold ramp steady
  output logic             RAMP_FAULT_CHARGE_O,          // charge toward fault trip
  output logic             FAULT_LATCHED_O,              // latched off
  input  wire logic        WB_CYC_I,                     // wishbone cycle
  input  wire logic        WB_STB_I,                     // wishbone strobe
  input  wire logic        WB_WE_I,                      // wishbone write
  input  wire logic [3:0]  WB_ADR_I,                     // byte address
  input  wire logic [3:0]  WB_SEL_I,                     // byte selects
  input  wire logic [31:0] WB_DAT_I,                     // write data
  output logic [31:0]      WB_DAT_O,                     // read data
  output logic             WB_ACK_O                      // acknowledge
);
  import prs_pkg::*;

  localparam logic [CNT_W-1:0] SS_LOAD   = CNT_W'(SOFT_START_CYCLES);
  localparam logic [CNT_W-1:0] TO_LOAD   = CNT_W'(FAULT_TIMEOUT_CYCLES);
  localparam logic [CNT_W-1:0] FAST_LOAD = CNT_W'(FAST_RAMP_CYCLES);

  prs_state_type              state;
  prs_state_type              next_state;
  logic [CAUSE_W-1:0]         next_cause;
  logic [CAUSE_W-1:0]         cause;
  logic                       variant;
  logic                       peak_d;
  logic                       peak_evt;
  logic [2:0]                 peak_count;
  logic [CNT_W-1:0]           ss_cnt;
  logic [CNT_W-1:0]           next_ss_cnt;
  logic [CNT_W-1:0]           to_cnt;
  logic [CNT_W-1:0]           fast_cnt;
  logic                       soft_start;
  logic                       run_fault;
  logic                       final_fault;
  logic [RAIL_W-1:0]          next_rails;
  logic                       wb_req;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic in_ramp(input prs_state_type s);
    in_ramp = (s == ST_RAMP1) || (s == ST_RAMP2) || (s == ST_RAMP3) ||
              (s == ST_RAMP4) || (s == ST_RAMP5) || (s == ST_RAMP6);
  endfunction

  // steps at or past the third ramp with the rails live
  function automatic logic rails_live(input prs_state_type s);
    rails_live = (s == ST_RAMP3) || (s == ST_RAMP4) || (s == ST_RAMP5) ||
                 (s == ST_RAMP6) || (s == ST_RUN) || (s == ST_TIMEOUT);
  endfunction

  function automatic logic [RAIL_W-1:0] rails_for(input prs_state_type s,
                                                   input logic          alt,
                                                   input logic          sup);
    logic [RAIL_W-1:0] r;
    logic              live;
    logic              late;
    r    = '0;
    live = rails_live(s);
    late = (s == ST_RAMP6) || (s == ST_RUN) || (s == ST_TIMEOUT);
    r[RAIL_REF] = alt ? sup : (live || s == ST_RAMP2);
    // switch opens as soon as a run fault is seen, ahead of the time-out latch
    r[RAIL_SW]  = live && s != ST_TIMEOUT;
    r[RAIL_BST] = live;
    r[RAIL_LOG] = alt ? (sup && s != ST_LATCHED) : live;
    r[RAIL_NEG] = live && s != ST_RAMP3;
    r[RAIL_DBE] = late;
    r[RAIL_POS] = late;
    rails_for = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // fault terms

  assign peak_evt    = RAMP_PEAK_I && !peak_d;
  assign soft_start  = ss_cnt != '0;
  // boost and logic rail comparators are blind while the rails are still ramping up
  assign run_fault   = !soft_start && (BOOST_FAULT_I || LOGIC_FAULT_I);
  assign final_fault = DBOOST_FAULT_I || SWITCH_FAULT_I || NEG_FAULT_I ||
                       DBEN_FAULT_I || POS_FAULT_I;

  ////////////////////////////////////////////////////////////////////////////
  // sequence state machine

  always_comb
  begin
    next_state = state;
    next_cause = '0;
    if (!SUPPLY_OK_I || !ENABLE_I)
    begin
      next_state = ST_OFF;
    end
    else if (OVERTEMP_I && state != ST_OFF && state != ST_LATCHED)
    begin
      next_state = ST_LATCHED;
      next_cause[CAUSE_TEMP] = 1'b1;
    end
    else
    begin
      unique case (state)
        ST_OFF:
          next_state = ST_RAMP1;
        ST_RAMP1:
          if (PRE_FAULT_I)
          begin
            next_state = ST_LATCHED;
            next_cause[CAUSE_PRE] = 1'b1;
          end
          else if (peak_evt)
            next_state = ST_RAMP2;
        ST_RAMP2:
          if (!REF_OK_I)
          begin
            next_state = ST_LATCHED;
            next_cause[CAUSE_REF] = 1'b1;
          end
          else if (peak_evt)
            next_state = ST_RAMP3;
        ST_RAMP3, ST_RAMP4, ST_RAMP5:
          if (run_fault)
          begin
            next_state = ST_LATCHED;
            next_cause[CAUSE_RAIL] = 1'b1;
          end
          else if (peak_evt)
            next_state = (state == ST_RAMP3) ? ST_RAMP4 :
                         (state == ST_RAMP4) ? ST_RAMP5 : ST_RAMP6;
        ST_RAMP6:
          if (run_fault)
          begin
            next_state = ST_LATCHED;
            next_cause[CAUSE_RAIL] = 1'b1;
          end
          else if (peak_evt && final_fault)
          begin
            next_state = ST_LATCHED;
            next_cause[CAUSE_FINAL] = 1'b1;
          end
          else if (peak_evt)
            next_state = ST_RUN;
        ST_RUN:
          if (run_fault || final_fault || !REF_OK_I)
            next_state = ST_TIMEOUT;
        ST_TIMEOUT:
          if (FAULT_TRIP_I || to_cnt == '0)
          begin
            next_state = ST_LATCHED;
            next_cause[CAUSE_TIMEOUT] = 1'b1;
          end
        ST_LATCHED:
          next_state = ST_LATCHED;
        default:
          next_state = ST_LATCHED;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state  <= ST_OFF;
      peak_d <= 1'b0;
    end
    else if (CE_I)
    begin
      state  <= next_state;
      peak_d <= RAMP_PEAK_I;
    end
  end

  // peaks seen in this attempt
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      peak_count <= '0;
    else if (CE_I)
    begin
      if (next_state == ST_OFF)
        peak_count <= '0;
      else if (in_ramp(state) && peak_evt && peak_count != PEAKS_FULL)
        peak_count <= peak_count + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timers

  always_comb
  begin
    next_ss_cnt = ss_cnt;
    if (!rails_live(next_state))
      next_ss_cnt = '0;
    else if (state == ST_RAMP2 && next_state == ST_RAMP3)
      next_ss_cnt = SS_LOAD;
    else if (ss_cnt != '0)
      next_ss_cnt = ss_cnt - CNT_W'(1);
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ss_cnt   <= '0;
      to_cnt   <= '0;
      fast_cnt <= '0;
    end
    else if (CE_I)
    begin
      ss_cnt <= next_ss_cnt;
      if (next_state == ST_TIMEOUT && state != ST_TIMEOUT)
        to_cnt <= TO_LOAD;
      else if (to_cnt != '0)
        to_cnt <= to_cnt - CNT_W'(1);
      if (next_state != ST_RAMP1)
        fast_cnt <= '0;
      else if (fast_cnt != FAST_LOAD)
        fast_cnt <= fast_cnt + CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin outputs, registered from the next state so they track it exactly

  assign next_rails = rails_for(next_state, variant, SUPPLY_OK_I);

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      REF_EN_O                    <= 1'b0;
      INPUT_SWITCH_ENABLE_N_O     <= 1'b1;
      BOOST_RAIL_EN_O             <= 1'b0;
      LOGIC_RAIL_EN_O             <= 1'b0;
      NEGATIVE_GATE_RAIL_EN_O     <= 1'b0;
      DELAYED_BOOST_ENABLE_N_O    <= 1'b0;
      DELAYED_BOOST_ENABLE_N_OE_O <= 1'b0;
      POSITIVE_GATE_RAIL_EN_O     <= 1'b0;
      SOFT_START_O                <= 1'b0;
      FAULT_LATCHED_O             <= 1'b0;
    end
    else if (CE_I)
    begin
      REF_EN_O                    <= next_rails[RAIL_REF];
      INPUT_SWITCH_ENABLE_N_O     <= !next_rails[RAIL_SW];
      BOOST_RAIL_EN_O             <= next_rails[RAIL_BST];
      LOGIC_RAIL_EN_O             <= next_rails[RAIL_LOG];
      NEGATIVE_GATE_RAIL_EN_O     <= next_rails[RAIL_NEG];
      // open drain: only ever drives low
      DELAYED_BOOST_ENABLE_N_O    <= 1'b0;
      DELAYED_BOOST_ENABLE_N_OE_O <= next_rails[RAIL_DBE];
      POSITIVE_GATE_RAIL_EN_O     <= next_rails[RAIL_POS];
      SOFT_START_O                <= next_ss_cnt != '0;
      FAULT_LATCHED_O             <= next_state == ST_LATCHED;
    end
  end

  // delay ramp control
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      RAMP_CHARGE_O       <= 1'b0;
      RAMP_FAST_O         <= 1'b0;
      RAMP_DISCHARGE_O    <= 1'b0;
      RAMP_HOLD_O         <= 1'b0;
      RAMP_FAULT_CHARGE_O <= 1'b0;
    end
    else if (CE_I)
    begin
      RAMP_CHARGE_O       <= in_ramp(next_state) && !(peak_evt && in_ramp(state));
      RAMP_FAST_O         <= next_state == ST_RAMP1 && fast_cnt != FAST_LOAD;
      RAMP_DISCHARGE_O    <= peak_evt && in_ramp(state) && in_ramp(next_state);
      RAMP_HOLD_O         <= next_state == ST_RUN;
      RAMP_FAULT_CHARGE_O <= next_state == ST_TIMEOUT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, ack dropped the cycle after

  assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;

  // fault cause is sticky until the next power-up attempt
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      variant <= CTRL_RESET;
      cause   <= '0;
    end
    else if (CE_I)
    begin
      if (wb_req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == ADR_CTRL)
        variant <= WB_DAT_I[CTRL_VARIANT];
      if (state == ST_OFF && next_state == ST_RAMP1)
        cause <= '0;
      else
        cause <= cause | next_cause;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end
    else if (CE_I)
    begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= '0;
      if (wb_req && !WB_WE_I)
      begin
        unique case (WB_ADR_I)
          ADR_CTRL:   WB_DAT_O[CTRL_VARIANT] <= variant;
          ADR_STATUS:
          begin
            WB_DAT_O[ST_STATE_LSB +: 4] <= state;
            WB_DAT_O[ST_PEAK_LSB +: 3]  <= peak_count;
            WB_DAT_O[ST_LATCH_BIT]      <= state == ST_LATCHED;
            WB_DAT_O[ST_SS_BIT]         <= soft_start;
          end
          ADR_CAUSE:  WB_DAT_O[CAUSE_W-1:0] <= cause;
          default:    WB_DAT_O <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_peak_limit: assert property (peak_count <= PEAKS_FULL)
    else $error("more than six ramp peaks counted");
  a_run_six_peaks: assert property (state == ST_RUN |-> peak_count == PEAKS_FULL)
    else $error("sequence complete without six peaks");
  a_switch_after_two: assert property (!INPUT_SWITCH_ENABLE_N_O |-> peak_count >= 3'h2)
    else $error("input switch on before second peak");
  a_latch_switch_off: assert property (state == ST_LATCHED |-> INPUT_SWITCH_ENABLE_N_O
                                       && !BOOST_RAIL_EN_O)
    else $error("input switch or boost on while latched");
  a_neg_before_pos: assert property (POSITIVE_GATE_RAIL_EN_O |-> NEGATIVE_GATE_RAIL_EN_O
                                     && peak_count >= 3'h5)
    else $error("positive gate rail ahead of negative rail");
  a_dben_drive: assert property (DELAYED_BOOST_ENABLE_N_OE_O |-> !DELAYED_BOOST_ENABLE_N_O
                                 && peak_count >= 3'h5)
    else $error("delayed boost enable driven too early");
  a_enable_idle: assert property (CE_I && !ENABLE_I |=> state == ST_OFF
                                  && !BOOST_RAIL_EN_O && INPUT_SWITCH_ENABLE_N_O
                                  && !FAULT_LATCHED_O)
    else $error("enable low did not return to idle");
  a_overtemp_shut: assert property (CE_I && OVERTEMP_I && ENABLE_I && SUPPLY_OK_I
                                    && state != ST_OFF |=> state == ST_LATCHED)
    else $error("over-temperature did not shut down");
  // a fault or disable may cut the window short, but only with the boost rail
  a_softstart_len: assert property ($rose(SOFT_START_O) |-> ss_cnt == SS_LOAD
                                    ##0 (SOFT_START_O || !BOOST_RAIL_EN_O)[*8])
    else $error("soft-start window too short");
  a_hold_in_run: assert property (state == ST_RUN |-> RAMP_HOLD_O && !RAMP_CHARGE_O)
    else $error("ramp not held after sequence");
  a_timeout_charge: assert property (CE_I && state == ST_RUN && next_state == ST_TIMEOUT
                                     |=> RAMP_FAULT_CHARGE_O && !RAMP_HOLD_O)
    else $error("fault did not charge ramp to trip level");
  a_ref_kept: assert property (CE_I && variant && SUPPLY_OK_I && ENABLE_I
                               && state == ST_LATCHED |=> REF_EN_O && !LOGIC_RAIL_EN_O)
    else $error("always-on variant dropped reference on fault");

endmodule // prs_sequencer

//--- test/prs_ramp_model.sv
/*
  Delay ramp capacitor model: gives the sequencer its peak and fault-trip events.
  Assumes charge and fault-charge controls come from the sequencer; no charge means discharged.
*/
module prs_ramp_model #(
  parameter int RAMP_CYC = 30,  // cycles to the upper threshold
  parameter int TRIP_CYC = 12   // cycles to the fault threshold
) (
  input  wire logic clk_i,        // bench clock
  input  wire logic charge_i,     // charge the ramp
  input  wire logic fault_chg_i,  // charge toward fault trip
  output logic      peak_o,       // upper threshold reached
  output logic      trip_o        // fault threshold reached
);
  timeunit 1ns;
  timeprecision 1ps;
  int lvl = 0;
  int flt = 0;
  ////////////////////////////////////////////////////////////////////////////
  // no charge means discharged: a stale peak would hide the next rising edge
  always @(posedge clk_i)
  begin
    lvl <= (charge_i && lvl < RAMP_CYC) ? lvl + 1 : (charge_i ? lvl : 0);
    flt <= fault_chg_i ? flt + 1 : 0;
  end
  assign peak_o = (lvl >= RAMP_CYC);
  assign trip_o = (flt >= TRIP_CYC);
endmodule // prs_ramp_model

//--- test/tb_prs_sequencer.sv
/*
  Testbench for the rail sequencer: power-up, early and late faults, latch, variant.
  Assumes the ramp model stands in for the capacitor and its comparators.
*/
module tb_prs_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import prs_pkg::*;
  logic CLK_I = 0, RST_N_I = 0, CE_I = 1, SUPPLY_OK_I = 0, ENABLE_I = 0, RAMP_PEAK_I;
  logic FAULT_TRIP_I, PRE_FAULT_I = 0, REF_OK_I = 1, OVERTEMP_I = 0, WB_ACK_O;
  logic WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0, REF_EN_O, INPUT_SWITCH_ENABLE_N_O;
  logic [3:0] WB_ADR_I = '0, WB_SEL_I = 4'hF;
  logic [31:0] WB_DAT_I = '0, WB_DAT_O, rd;
  logic [6:0] flt = '0;
  logic BOOST_RAIL_EN_O, LOGIC_RAIL_EN_O, SOFT_START_O, NEGATIVE_GATE_RAIL_EN_O, RAMP_FAST_O;
  logic DELAYED_BOOST_ENABLE_N_O, DELAYED_BOOST_ENABLE_N_OE_O, POSITIVE_GATE_RAIL_EN_O;
  logic RAMP_CHARGE_O, RAMP_DISCHARGE_O, RAMP_HOLD_O, RAMP_FAULT_CHARGE_O, FAULT_LATCHED_O;
  int fail_count = 0, checked = 0;
  // {pos, delayed boost, neg, logic, boost, switch on, ref}
  wire [6:0] seen = {POSITIVE_GATE_RAIL_EN_O, DELAYED_BOOST_ENABLE_N_OE_O,
    NEGATIVE_GATE_RAIL_EN_O, LOGIC_RAIL_EN_O, BOOST_RAIL_EN_O, ~INPUT_SWITCH_ENABLE_N_O, REF_EN_O};
  prs_sequencer #(.SOFT_START_CYCLES(16), .FAULT_TIMEOUT_CYCLES(20), .FAST_RAMP_CYCLES(4))
  prs_sequencer_i (.CLK_I, .RST_N_I, .CE_I, .SUPPLY_OK_I, .ENABLE_I, .RAMP_PEAK_I, .FAULT_TRIP_I,
    .PRE_FAULT_I, .REF_OK_I, .OVERTEMP_I, .BOOST_FAULT_I(flt[0]), .LOGIC_FAULT_I(flt[1]),
    .NEG_FAULT_I(flt[2]), .POS_FAULT_I(flt[3]), .DBOOST_FAULT_I(flt[4]),
    .SWITCH_FAULT_I(flt[5]), .DBEN_FAULT_I(flt[6]), .REF_EN_O, .INPUT_SWITCH_ENABLE_N_O,
    .BOOST_RAIL_EN_O, .LOGIC_RAIL_EN_O, .SOFT_START_O, .NEGATIVE_GATE_RAIL_EN_O,
    .DELAYED_BOOST_ENABLE_N_O, .DELAYED_BOOST_ENABLE_N_OE_O, .POSITIVE_GATE_RAIL_EN_O,
    .RAMP_CHARGE_O, .RAMP_FAST_O, .RAMP_DISCHARGE_O, .RAMP_HOLD_O, .RAMP_FAULT_CHARGE_O,
    .FAULT_LATCHED_O, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
    .WB_DAT_O, .WB_ACK_O);
  prs_ramp_model prs_ramp_model_i (.clk_i(CLK_I), .charge_i(RAMP_CHARGE_O),
    .fault_chg_i(RAMP_FAULT_CHARGE_O), .peak_o(RAMP_PEAK_I), .trip_o(FAULT_TRIP_I));
  always #20 CLK_I = ~CLK_I;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [6:0] rails(int k, bit alt);
    return {k >= 5, k >= 5, k >= 3, k >= 2 || alt, k >= 2, k >= 2, k >= 1 || alt};
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // sel: 0 discharge, 1 hold, 2 latched, 3 fault charge
  task automatic wait_on(int sel);
    logic [3:0] v;
    repeat (400)
    begin
      @(posedge CLK_I);
      #1;
      v = {RAMP_FAULT_CHARGE_O, FAULT_LATCHED_O, RAMP_HOLD_O, RAMP_DISCHARGE_O};
      if (v[sel] === 1'b1)
        return;
    end
    chk("wait", 1, 0);
    stop_test();
  endtask
  task automatic wb(logic we, logic [3:0] a, logic [31:0] d);
    int n;
    @(posedge CLK_I);
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} <= {2'b11, we, a, d};
    for (n = 0; n < 20 && WB_ACK_O !== 1'b1; n++)
      @(posedge CLK_I);
    rd = WB_DAT_O;
    {WB_CYC_I, WB_STB_I} <= 2'b00;
    if (n == 20)
    begin
      chk("wb ack", 1, 0);
      stop_test();
    end
  endtask
  // clears faults, toggles enable; the latch must drop only here
  task automatic restart(bit alt);
    @(posedge CLK_I);
    ENABLE_I <= 0;
    {PRE_FAULT_I, OVERTEMP_I, REF_OK_I} <= 3'b001;
    flt <= '0;
    repeat (2) @(posedge CLK_I);
    #1;
    chk("latch off", 0, FAULT_LATCHED_O);
    chk("idle rails", rails(0, alt), seen);
    @(posedge CLK_I);
    ENABLE_I <= 1;
    $display("test done, checks %0d", checked);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int k;
    void'($urandom(92932));
    repeat (6) @(posedge CLK_I);
    chk("reset rails", 0, seen);
    RST_N_I <= 1;
    wb(0, 4'hC, 0);
    chk("unmapped", 0, rd);
    SUPPLY_OK_I <= 1;
    restart(0);
    @(posedge CLK_I);
    #1;
    chk("fast ramp", 1, RAMP_FAST_O);
    for (k = 1; k < 6; k++)
    begin
      wait_on(0);
      chk("step rails", rails(k, 0), seen);
      chk("soft-start", k == 2, SOFT_START_O);
    end
    wait_on(1);
    chk("run rails", rails(6, 0), seen);
    chk("dben level", 0, DELAYED_BOOST_ENABLE_N_O);
    wb(0, ADR_STATUS, 0);
    chk("peaks", 7'h64, rd[6:0]);
    repeat ($urandom_range(9)) @(posedge CLK_I);
    flt[$urandom_range(6)] <= 1;
    wait_on(3);
    chk("switch off", 1, INPUT_SWITCH_ENABLE_N_O);
    wait_on(2);
    chk("latched rails", 0, seen);
    flt <= '0;
    repeat (9) @(posedge CLK_I);
    chk("still latched", 1, FAULT_LATCHED_O);
    wb(0, ADR_CAUSE, 0);
    chk("run cause", 1, rd[CAUSE_TIMEOUT]);
    for (k = 0; k < 4; k++)
    begin
      restart(0);
      repeat (k == 3 ? 5 : k) wait_on(0);
      {PRE_FAULT_I, REF_OK_I, OVERTEMP_I} <= {k == 0, k != 1, k == 2};
      flt <= {k == 3, 6'h00};
      wait_on(2);
      chk("early rails", 0, seen);
      wb(0, ADR_CAUSE, 0);
      chk("cause", 32'h1 << (k == 3 ? 4 : k), rd);
    end
    wb(1, ADR_CTRL, 1);
    restart(1);
    OVERTEMP_I <= 1;
    wait_on(2);
    chk("variant latch", 7'h01, seen);
    restart(1);
    stop_test();
  end
endmodule // tb_prs_sequencer
